// ===== conversion_clock_select_sequencer.sv
/*
 * Top of the converter sequencing control: AHB-Lite register file,
 * trigger selection, start/abort handshake and result formatting.
 * Assumes timer and comparator event inputs are on clk; compRaw and
 * rcClockPin come from analog circuits and are synchronised here.
 */
`timescale 1ns/100ps
module conversion_clock_select_sequencer import conversion_clock_select_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic timerZeroOverflow,
	input wire logic timerOneOverflow,
	input wire logic timerTwoPeriodMatch,
	input wire logic comparatorOneSyncedOutput,
	input wire logic comparatorTwoSyncedOutput,
	input wire logic compRaw,
	input wire logic rcClockPin,
	output conversion_clock_select_analog_t analogOut,
	output logic conversionDoneFlag
);
	// ==========================================================
	// Registers.
	logic converterEnable;
	logic goBit;
	logic [4:0] inputChannelSelect;
	logic resultFormatSelect;
	logic [2:0] conversionClockSelect;
	logic [1:0] positiveReferenceSelect;
	logic [2:0] autoTriggerSelect;
	logic [7:0] resultHighByte;
	logic [7:0] resultLowByte;
	logic wrPending;
	logic [7:0] wrAddr;
	logic trigPrev;
	logic [2:0] delayCount;
	logic engineStart;
	logic compSync1;
	logic compSync2;
	logic engineBusy;
	logic [9:0] engineTrial;
	logic loadStrobe;
	logic [9:0] loadValue;
	logic halfTick;

	// ==========================================================
	// Bus decode.
	wire addrPhase = hsel & hready & htrans[1];
	wire [7:0] addrOfs = haddr[7:0];
	wire wrCtrl0 = wrPending & (wrAddr == OFS_CONTROL_ZERO);
	wire wrCtrl1 = wrPending & (wrAddr == OFS_CONTROL_ONE);
	wire wrCtrl2 = wrPending & (wrAddr == OFS_CONTROL_TWO);
	wire wrHigh = wrPending & (wrAddr == OFS_RESULT_HIGH);
	wire wrLow = wrPending & (wrAddr == OFS_RESULT_LOW);
	wire wrStatus = wrPending & (wrAddr == OFS_STATUS);

	// Unimplemented bits are simply never stored, so they read zero.
	wire [7:0] ctrl0Word = {1'b0, inputChannelSelect, goBit, converterEnable};
	wire [7:0] ctrl1Word = {resultFormatSelect, conversionClockSelect, 2'b00,
		positiveReferenceSelect};
	wire [7:0] ctrl2Word = {1'b0, autoTriggerSelect, 4'h0};

	logic [7:0] readByte;
	always_comb begin
		case (addrOfs)
			OFS_CONTROL_ZERO: readByte = ctrl0Word;
			OFS_CONTROL_ONE: readByte = ctrl1Word;
			OFS_CONTROL_TWO: readByte = ctrl2Word;
			OFS_RESULT_HIGH: readByte = resultHighByte;
			OFS_RESULT_LOW: readByte = resultLowByte;
			OFS_STATUS: readByte = {7'h00, conversionDoneFlag};
			default: readByte = 8'h00;
		endcase
	end
	wire [31:0] next_hrdata = (addrPhase && !hwrite) ? {24'h000000, readByte} : 32'h00000000;

	// ==========================================================
	// Start, abort and trigger.
	logic trigSource;
	always_comb begin
		case (autoTriggerSelect)
			TRIG_TIMER_ZERO: trigSource = timerZeroOverflow;
			TRIG_TIMER_ONE: trigSource = timerOneOverflow;
			TRIG_TIMER_TWO: trigSource = timerTwoPeriodMatch;
			TRIG_COMP_ONE: trigSource = comparatorOneSyncedOutput;
			TRIG_COMP_TWO: trigSource = comparatorTwoSyncedOutput;
			default: trigSource = 1'b0;
		endcase
	end

	// The timer events are only observed here, never consumed, so each timer
	// still raises its own flag outside this block.
	// Timing limits are not enforced on the trigger path.
	wire trigEdge = trigSource & ~trigPrev;
	wire trigStart = trigEdge & converterEnable & ~goBit;
	wire swStart = wrCtrl0 & hwdata[POS_GO] & ~goBit & converterEnable;
	wire swAbort = wrCtrl0 & ~hwdata[POS_GO] & goBit;
	wire disableNow = wrCtrl0 & ~hwdata[POS_ENABLE];
	wire startAny = swStart | trigStart;
	wire rcSelected = (conversionClockSelect[1:0] == CLOCK_RC_CODE);
	wire engineAbort = swAbort | disableNow;
	wire next_engineStart = (startAny & ~rcSelected & ~engineAbort)
		| (delayCount == 3'h1 & ~engineAbort);
	// A start that meets an abort or a disable is dropped, else the bit would stick.
	wire next_goBit = (startAny & ~engineAbort)
		| (goBit & ~loadStrobe & ~engineAbort);
	wire next_doneFlag = loadStrobe | (conversionDoneFlag & ~(wrStatus & hwdata[POS_DONE]));

	wire chanHit = (inputChannelSelect >= CHAN_EXT_FIRST && inputChannelSelect <= CHAN_EXT_LAST)
		|| (inputChannelSelect >= CHAN_INT_FIRST);

	// ==========================================================
	// Bus and control registers; all controls reset to zero.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			wrPending <= 1'b0;
			wrAddr <= 8'h00;
		end else begin
			hrdata <= next_hrdata;
			wrPending <= addrPhase & hwrite;
			if (addrPhase) begin
				wrAddr <= addrOfs;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			{inputChannelSelect, converterEnable} <= CONTROL_RESET[5:0];
			{resultFormatSelect, conversionClockSelect} <= CONTROL_RESET[3:0];
			positiveReferenceSelect <= CONTROL_RESET[1:0];
			autoTriggerSelect <= CONTROL_RESET[2:0];
		end else begin
			if (wrCtrl0) begin
				inputChannelSelect <= hwdata[POS_CHANNEL +: 5];
				converterEnable <= hwdata[POS_ENABLE];
			end
			if (wrCtrl1) begin
				resultFormatSelect <= hwdata[POS_FORMAT];
				conversionClockSelect <= hwdata[POS_CLOCK +: 3];
				positiveReferenceSelect <= hwdata[POS_REFERENCE +: 2];
			end
			if (wrCtrl2) begin
				autoTriggerSelect <= hwdata[POS_TRIGGER +: 3];
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			goBit <= 1'b0;
			conversionDoneFlag <= 1'b0;
			trigPrev <= 1'b0;
			delayCount <= 3'h0;
			engineStart <= 1'b0;
			compSync1 <= 1'b0;
			compSync2 <= 1'b0;
		end else begin
			goBit <= next_goBit;
			conversionDoneFlag <= next_doneFlag;
			trigPrev <= trigSource;
			engineStart <= next_engineStart;
			compSync1 <= compRaw;
			compSync2 <= compSync1;
			if (engineAbort) begin
				delayCount <= 3'h0;
			end else if (startAny && rcSelected) begin
				delayCount <= INSTR_CYCLE_CLOCKS;
			end else if (delayCount != 3'h0) begin
				delayCount <= delayCount - 3'h1;
			end
		end
	end

	// Result bytes have no reset: a reset leaves them unchanged.
	always_ff @(posedge clk) begin
		if (loadStrobe && resultFormatSelect) begin
			resultHighByte <= {6'h00, loadValue[9:8]};
			resultLowByte <= loadValue[7:0];
		end else if (loadStrobe) begin
			resultHighByte <= loadValue[9:2];
			resultLowByte <= {loadValue[1:0], 6'h00};
		end else begin
			if (wrHigh) begin
				resultHighByte <= hwdata[7:0];
			end
			if (wrLow) begin
				resultLowByte <= hwdata[7:0];
			end
		end
	end

	// Front-end outputs are registered so the analog side sees clean levels.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			analogOut <= '0;
		end else begin
			analogOut.powered <= converterEnable;
			analogOut.sampleClosed <= converterEnable & ~engineBusy;
			analogOut.channelCode <= inputChannelSelect;
			analogOut.channelConnected <= chanHit;
			analogOut.refSelect <= positiveReferenceSelect;
			analogOut.refValid <= (positiveReferenceSelect != 2'h1);
			analogOut.dacTrial <= engineTrial;
		end
	end

	// ==========================================================
	// Conversion clock and sequencer.
	conversion_clock_select_tad_divider u_divider (
		.clk(clk),
		.reset_n(reset_n),
		.run(engineBusy),
		.clockSelect(conversionClockSelect),
		.rcClockPin(rcClockPin),
		.halfTick(halfTick)
	);

	conversion_clock_select_sar_engine u_engine (
		.clk(clk),
		.reset_n(reset_n),
		.start(engineStart),
		.abort(engineAbort),
		.halfTick(halfTick),
		.compAbove(compSync2),
		.busy(engineBusy),
		.trialCode(engineTrial),
		.loadStrobe(loadStrobe),
		.loadValue(loadValue)
	);

	// ==========================================================
	// Checks.
	sequence s_rc_wait;
		!engineStart && !$past(engineStart) && !$past(engineStart, 2) && !$past(engineStart, 3)
			##1 engineStart;
	endsequence

	a_trig_sets_go: assert property (@(posedge clk) disable iff (!reset_n)
		trigStart && !engineAbort |=> goBit)
		else $error("trigger edge did not set the busy bit");
	a_trig_none_idle: assert property (@(posedge clk) disable iff (!reset_n)
		autoTriggerSelect == TRIG_NONE |-> !trigStart)
		else $error("trigger fired with no source selected");
	a_chan_route: assert property (@(posedge clk) disable iff (!reset_n)
		chanHit |=> analogOut.channelConnected)
		else $error("valid channel code not connected");
	a_done_clears_go: assert property (@(posedge clk) disable iff (!reset_n)
		loadStrobe && !startAny |=> !goBit && conversionDoneFlag)
		else $error("completion did not clear busy and set flag");
	a_disable_off: assert property (@(posedge clk) disable iff (!reset_n)
		!converterEnable |-> !trigStart ##1 !analogOut.powered)
		else $error("disabled converter still powered or triggered");
	a_right_format: assert property (@(posedge clk) disable iff (!reset_n)
		loadStrobe && resultFormatSelect |=> resultHighByte[7:2] == 6'h00
			&& resultLowByte == $past(loadValue[7:0]))
		else $error("right format load wrong");
	a_left_format: assert property (@(posedge clk) disable iff (!reset_n)
		loadStrobe && !resultFormatSelect |=> resultHighByte == $past(loadValue[9:2])
			&& resultLowByte[5:0] == 6'h00)
		else $error("left format load wrong");
	a_rc_delay: assert property (@(posedge clk) disable iff (!reset_n)
		startAny && rcSelected && !engineAbort ##1 !engineAbort [*4] |-> s_rc_wait)
		else $error("RC start delay not one instruction cycle");
	a_busy_ignore: assert property (@(posedge clk) disable iff (!reset_n)
		goBit && trigEdge && delayCount != 3'h1 |=> !engineStart)
		else $error("trigger restarted a running conversion");
	a_reserved_zero: assert property (@(posedge clk) disable iff (!reset_n)
		1'b1 |-> !ctrl0Word[7] && ctrl1Word[3:2] == 2'b00 && ctrl2Word[7] == 1'b0
			&& ctrl2Word[3:0] == 4'h0)
		else $error("unimplemented bit reads nonzero");

endmodule : conversion_clock_select_sequencer

// ===== conversion_clock_select_pkg.sv
/*
 * Shared constants and types of the converter sequencing control block.
 * Assumes a single 100 MHz system clock and an AHB-Lite register port.
 */
package conversion_clock_select_pkg;

	// ==========================================================
	// Register map (byte offsets) and field positions.
	localparam logic [7:0] OFS_CONTROL_ZERO = 8'h00;
	localparam logic [7:0] OFS_CONTROL_ONE = 8'h04;
	localparam logic [7:0] OFS_CONTROL_TWO = 8'h08;
	localparam logic [7:0] OFS_RESULT_HIGH = 8'h0C;
	localparam logic [7:0] OFS_RESULT_LOW = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	localparam int POS_ENABLE = 0;
	localparam int POS_GO = 1;
	localparam int POS_CHANNEL = 2;
	localparam int POS_REFERENCE = 0;
	localparam int POS_CLOCK = 4;
	localparam int POS_FORMAT = 7;
	localparam int POS_TRIGGER = 4;
	localparam int POS_DONE = 0;

	localparam logic [7:0] CONTROL_RESET = 8'h00;

	// ==========================================================
	// Encodings.
	localparam logic [2:0] TRIG_NONE = 3'h0;
	localparam logic [2:0] TRIG_TIMER_ZERO = 3'h3;
	localparam logic [2:0] TRIG_TIMER_ONE = 3'h4;
	localparam logic [2:0] TRIG_TIMER_TWO = 3'h5;
	localparam logic [2:0] TRIG_COMP_ONE = 3'h6;
	localparam logic [2:0] TRIG_COMP_TWO = 3'h7;

	localparam logic [4:0] CHAN_EXT_FIRST = 5'h03;
	localparam logic [4:0] CHAN_EXT_LAST = 5'h0B;
	localparam logic [4:0] CHAN_INT_FIRST = 5'h1D;

	localparam logic [1:0] CLOCK_RC_CODE = 2'h3;

	// ==========================================================
	// Timing: one instruction cycle is four system clocks.
	localparam int CLK_PERIOD_NS = 10;
	localparam int INSTR_CYCLE_NS = 40;
	localparam logic [2:0] INSTR_CYCLE_CLOCKS = 3'(INSTR_CYCLE_NS / CLK_PERIOD_NS);
	// Eleven and a half bit periods counted in half periods.
	localparam logic [4:0] CONV_HALF_PERIODS = 5'h17;
	localparam logic [4:0] FIRST_DECISION_HALF = 5'h04;

	// ==========================================================
	// Analog front-end control bundle.
	typedef struct packed {
		logic powered;
		logic sampleClosed;
		logic [4:0] channelCode;
		logic channelConnected;
		logic [1:0] refSelect;
		logic refValid;
		logic [9:0] dacTrial;
	} conversion_clock_select_analog_t;

endpackage : conversion_clock_select_pkg

// ===== conversion_clock_select_tad_divider.sv
/*
 * Half bit-period tick generator for the conversion clock.
 * Assumes rcClockPin is an asynchronous oscillator pin, much slower than clk.
 */
`timescale 1ns/100ps
module conversion_clock_select_tad_divider import conversion_clock_select_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic run,
	input wire logic [2:0] clockSelect,
	input wire logic rcClockPin,
	output logic halfTick
);
	logic [5:0] divCount;
	logic [5:0] halfLimit;
	logic rcSync1;
	logic rcSync2;
	logic rcSync3;

	// ==========================================================
	// Divider selection.
	always_comb begin
		case (clockSelect)
			3'h0: halfLimit = 6'h01;
			3'h4: halfLimit = 6'h02;
			3'h1: halfLimit = 6'h04;
			3'h5: halfLimit = 6'h08;
			3'h2: halfLimit = 6'h10;
			3'h6: halfLimit = 6'h20;
			default: halfLimit = 6'h01;
		endcase
	end

	wire rcSelected = (clockSelect[1:0] == CLOCK_RC_CODE);
	wire divWrap = (divCount == halfLimit - 6'h01);
	wire rcEdge = rcSync2 & ~rcSync3;
	wire next_halfTick = run & (rcSelected ? rcEdge : divWrap);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rcSync1 <= 1'b0;
			rcSync2 <= 1'b0;
			rcSync3 <= 1'b0;
			divCount <= 6'h00;
			halfTick <= 1'b0;
		end else begin
			rcSync1 <= rcClockPin;
			rcSync2 <= rcSync1;
			rcSync3 <= rcSync2;
			divCount <= (!run || divWrap) ? 6'h00 : divCount + 6'h01;
			halfTick <= next_halfTick;
		end
	end

	a_div_fastest: assert property (@(posedge clk) disable iff (!reset_n)
		run && clockSelect == 3'h0 && $past(run) && $past(clockSelect) == 3'h0 |=> halfTick)
		else $error("fastest divider missed a half tick");

endmodule : conversion_clock_select_tad_divider

// ===== conversion_clock_select_sar_engine.sv
/*
 * Successive approximation sequencer: 23 half bit periods per conversion.
 * Assumes compAbove is already synchronised to clk.
 */
`timescale 1ns/100ps
module conversion_clock_select_sar_engine import conversion_clock_select_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic abort,
	input wire logic halfTick,
	input wire logic compAbove,
	output logic busy,
	output logic [9:0] trialCode,
	output logic loadStrobe,
	output logic [9:0] loadValue
);
	logic [4:0] halfCount;
	logic [9:0] probe;
	logic [9:0] filled;
	logic [4:0] tickSeen;

	wire decide = busy & halfTick & (halfCount >= FIRST_DECISION_HALF) & ~halfCount[0];
	wire finish = busy & halfTick & (halfCount == CONV_HALF_PERIODS - 5'h01);
	wire [9:0] kept = compAbove ? trialCode : (trialCode & ~probe);
	wire [9:0] fillMask = probe | (probe - 10'h001);
	wire lastBit = |(trialCode & {probe[8:0], 1'b0});

	// ==========================================================
	// Abort fill: undecided bits copy the last decided bit.
	genvar i;
	for (i = 0; i < 10; i++) begin : g_fill
		assign filled[i] = fillMask[i] ? lastBit : trialCode[i];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy <= 1'b0;
			halfCount <= 5'h00;
			probe <= 10'h000;
			trialCode <= 10'h000;
			loadStrobe <= 1'b0;
			loadValue <= 10'h000;
		end else begin
			loadStrobe <= (busy & abort) | finish;
			// A start met by an abort in the same cycle is dropped, so a quick
			// clear of the start bit never leaves the engine running unowned.
			if (start && !busy && !abort) begin
				busy <= 1'b1;
				halfCount <= 5'h00;
				probe <= 10'h200;
				trialCode <= 10'h200;
			end else if (busy && abort) begin
				busy <= 1'b0;
				loadValue <= filled;
			end else if (busy && halfTick) begin
				halfCount <= halfCount + 5'h01;
				if (decide) begin
					trialCode <= kept | {1'b0, probe[9:1]};
					probe <= {1'b0, probe[9:1]};
				end
				if (finish) begin
					busy <= 1'b0;
					loadValue <= kept;
				end
			end
		end
	end

	// Helper count of half ticks seen in the running conversion.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tickSeen <= 5'h00;
		end else if (start && !busy) begin
			tickSeen <= 5'h00;
		end else if (busy && halfTick) begin
			tickSeen <= tickSeen + 5'h01;
		end
	end

	a_conv_length: assert property (@(posedge clk) disable iff (!reset_n)
		finish |=> tickSeen == 5'h17 && loadStrobe && !busy)
		else $error("conversion did not take 23 half periods");

	a_abort_load: assert property (@(posedge clk) disable iff (!reset_n)
		busy && abort |=> loadStrobe && !busy && loadValue == $past(filled))
		else $error("abort did not load the partial result");

endmodule : conversion_clock_select_sar_engine

// ===== test_adc_sequencing_control.sv
/*
 * Self-checking bench for the converter sequencing control top, driven over AHB-Lite.
 * Assumes the package offsets, one 100 MHz clock and zero wait-state bus answers.
 */
`timescale 1ns/100ps
module test_adc_sequencing_control import conversion_clock_select_pkg::*;;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, conversionDoneFlag;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [4:0] trg;
	logic compRaw = 1'b0;
	logic rcClockPin = 1'b0;
	logic [9:0] vin;
	conversion_clock_select_analog_t analogOut;
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	int rcCnt = 0;
	int dt, t;
	logic [2:0] codes [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
	int halves [6] = '{1, 2, 4, 8, 16, 32};

	conversion_clock_select_sequencer dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.timerZeroOverflow(trg[0]), .timerOneOverflow(trg[1]),
		.timerTwoPeriodMatch(trg[2]), .comparatorOneSyncedOutput(trg[3]),
		.comparatorTwoSyncedOutput(trg[4]), .compRaw(compRaw), .rcClockPin(rcClockPin),
		.analogOut(analogOut), .conversionDoneFlag(conversionDoneFlag));

	always #5 clk = ~clk;

	// ==========================================================
	// Analog stand-in: the input sits half a step above vin, so the comparison is never a tie.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		compRaw <= (analogOut.dacTrial <= vin);
		rcCnt <= (rcCnt == 4) ? 0 : rcCnt + 1;
		if (rcCnt == 4) begin
			rcClockPin <= ~rcClockPin;
		end
	end

	// ==========================================================
	// Bus and comparison tasks.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do begin
			@(posedge clk);
		end while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, wd};
		do begin
			@(posedge clk);
		end while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task automatic rdc(input string n, input logic [7:0] a, input logic [7:0] e);
		logic [31:0] r;
		bus(1'b0, a, 8'h00, r);
		check(n, r, {24'h000000, e});
	endtask : rdc

	task automatic waitDone;
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (conversionDoneFlag !== 1'b1 && n < 3000);
		if (n >= 3000) begin
			check("done wait", 32'h0, 32'h1);
		end
	endtask : waitDone

	task automatic pulse(input int i);
		@(posedge clk);
		trg[i] <= 1'b1;
		@(posedge clk);
		trg[i] <= 1'b0;
	endtask : pulse

	task automatic wrap_up;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	// ==========================================================
	// Main sequence.
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		trg = 5'h00;
		vin = 10'h000;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		rdc("control zero reset", OFS_CONTROL_ZERO, 8'h00);
		check("response", {31'h0, hresp}, 32'h0);
		rdc("control one reset", OFS_CONTROL_ONE, 8'h00);
		rdc("control two reset", OFS_CONTROL_TWO, 8'h00);
		rdc("unmapped", 8'h20, 8'h00);
		// Go in the enabling write must be ignored, so zero bit 1 comes back too.
		wr(OFS_CONTROL_ZERO, 8'hFF);
		rdc("control zero mask", OFS_CONTROL_ZERO, 8'h7D);
		check("powered", {31'h0, analogOut.powered}, 32'h1);
		check("sample closed", {31'h0, analogOut.sampleClosed}, 32'h1);
		wr(OFS_CONTROL_ZERO, 8'h00);
		repeat (2) @(negedge clk);
		check("unpowered", {31'h0, analogOut.powered}, 32'h0);
		wr(OFS_CONTROL_ONE, 8'hFF);
		rdc("control one mask", OFS_CONTROL_ONE, 8'hF3);
		wr(OFS_CONTROL_TWO, 8'hFF);
		rdc("control two mask", OFS_CONTROL_TWO, 8'h70);
		wr(OFS_CONTROL_TWO, 8'h00);
		for (int ch = 0; ch < 32; ch++) begin
			wr(OFS_CONTROL_ZERO, {1'b0, 5'(ch), 2'b00});
			repeat (2) @(negedge clk);
			check("channel code", {27'h0, analogOut.channelCode}, 32'(ch));
			check("channel link", {31'h0, analogOut.channelConnected},
				{31'h0, (ch >= 3 && ch <= 11) || ch >= 29});
		end
		for (int r = 0; r < 4; r++) begin
			wr(OFS_CONTROL_ONE, {6'h00, 2'(r)});
			repeat (2) @(negedge clk);
			check("reference", {30'h0, analogOut.refSelect}, 32'(r));
			check("reference valid", {31'h0, analogOut.refValid}, {31'h0, r != 1});
		end
		// ==========================================================
		// Divider codes, right justified, slowest code last so its result is exact.
		vin <= 10'h2A5;
		wr(OFS_CONTROL_ZERO, 8'h0D);
		repeat (20) @(posedge clk);
		for (int k = 0; k < 6; k++) begin
			wr(OFS_CONTROL_ONE, {1'b1, codes[k], 4'h2});
			wr(OFS_STATUS, 8'h01);
			wr(OFS_CONTROL_ZERO, 8'h0F);
			t = cyc;
			waitDone();
			dt = cyc - t;
			check("conversion time", {31'h0, dt >= 23 * halves[k] && dt <= 23 * halves[k] + 8},
				32'h1);
			rdc("go cleared", OFS_CONTROL_ZERO, 8'h0D);
			rdc("done flag", OFS_STATUS, 8'h01);
		end
		rdc("right high", OFS_RESULT_HIGH, 8'h02);
		rdc("right low", OFS_RESULT_LOW, 8'hA5);
		wr(OFS_CONTROL_ONE, 8'h62);
		wr(OFS_STATUS, 8'h01);
		rdc("flag clear", OFS_STATUS, 8'h00);
		wr(OFS_CONTROL_ZERO, 8'h0F);
		waitDone();
		rdc("left high", OFS_RESULT_HIGH, 8'hA9);
		rdc("left low", OFS_RESULT_LOW, 8'h40);
		// ==========================================================
		// Abort after three decisions: undecided bits copy the last zero.
		vin <= 10'h200;
		wr(OFS_CONTROL_ONE, 8'hE2);
		wr(OFS_STATUS, 8'h01);
		wr(OFS_CONTROL_ZERO, 8'h0F);
		repeat (300) @(posedge clk);
		wr(OFS_CONTROL_ZERO, 8'h0D);
		repeat (3) @(negedge clk);
		rdc("abort go", OFS_CONTROL_ZERO, 8'h0D);
		rdc("abort flag", OFS_STATUS, 8'h01);
		rdc("abort high", OFS_RESULT_HIGH, 8'h02);
		rdc("abort low", OFS_RESULT_LOW, 8'h00);
		// ==========================================================
		// Every trigger code against every source, with a second edge mid-conversion.
		wr(OFS_CONTROL_ONE, 8'h42);
		for (int c = 0; c < 8; c++) begin
			wr(OFS_CONTROL_TWO, {1'b0, 3'(c), 4'h0});
			for (int i = 0; i < 5; i++) begin
				wr(OFS_STATUS, 8'h01);
				pulse(i);
				t = cyc;
				rdc("trigger start", OFS_CONTROL_ZERO, (c == i + 3) ? 8'h0F : 8'h0D);
				if (c == i + 3) begin
					repeat (15) @(posedge clk);
					check("sample open", {31'h0, analogOut.sampleClosed}, 32'h0);
					pulse(i);
					waitDone();
					check("retrigger ignored", {31'h0, (cyc - t) <= 54}, 32'h1);
				end
			end
		end
		wr(OFS_CONTROL_TWO, 8'h00);
		// ==========================================================
		// Dedicated oscillator clock.
		vin <= 10'h155;
		wr(OFS_CONTROL_ONE, 8'hB2);
		wr(OFS_STATUS, 8'h01);
		wr(OFS_CONTROL_ZERO, 8'h0F);
		rdc("oscillator busy", OFS_CONTROL_ZERO, 8'h0F);
		waitDone();
		rdc("oscillator high", OFS_RESULT_HIGH, 8'h01);
		rdc("oscillator low", OFS_RESULT_LOW, 8'h55);
		// ==========================================================
		// A second reset clears controls but keeps the result bytes.
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rdc("control zero rereset", OFS_CONTROL_ZERO, 8'h00);
		rdc("control one rereset", OFS_CONTROL_ONE, 8'h00);
		rdc("high kept", OFS_RESULT_HIGH, 8'h01);
		rdc("low kept", OFS_RESULT_LOW, 8'h55);
		check("flag rereset", {31'h0, conversionDoneFlag}, 32'h0);
		wr(OFS_RESULT_HIGH, 8'h5A);
		rdc("high writable", OFS_RESULT_HIGH, 8'h5A);
		wrap_up();
	end

	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		wrap_up();
	end
endmodule : test_adc_sequencing_control
